// [src/sahi_pkg.sv]
// shared constants and types of the converter host interface
package sahi_pkg;
  localparam int          RESULT_W        = 12;
  localparam int          DATA_W          = 8;
  localparam int          CMD_W           = 3;
  localparam int          PIN_W           = 7;
  localparam int          BIT_IDX_W       = 4;
  // command word fields: mode in bits 1:0, output code select in bit 2
  localparam int          CMD_MODE_LSB    = 0;
  localparam int          CMD_MODE_MSB    = 1;
  localparam int          CMD_CODE_BIT    = 2;
  localparam logic [2:0]  CMD_RESET       = 3'h0;
  // host programmable conversion modes
  localparam logic [1:0]  MODE_WR_START   = 2'h0;
  localparam logic [1:0]  MODE_RD_START   = 2'h1;
  localparam logic [1:0]  MODE_DMA        = 2'h2;
  localparam logic [1:0]  MODE_WR_FREE    = 2'h3;
  // synchronised pin vector {select_n, read_n, write_n, cmd_data, d2..d0}
  localparam int          PIN_CS_BIT      = 6;
  localparam int          PIN_RD_BIT      = 5;
  localparam int          PIN_WR_BIT      = 4;
  localparam int          PIN_CD_BIT      = 3;
  localparam logic [6:0]  PIN_IDLE        = 7'h70;
  // successive approximation
  localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;
  localparam logic [11:0] SAR_CODE_RESET  = 12'h000;
  localparam logic [3:0]  SAR_TOP_BIT     = 4'hB;
  localparam logic [11:0] SIGN_FLIP       = 12'h800;
  localparam int          CONV_CYCLES     = RESULT_W;
  // data bus drive patterns
  localparam logic [7:0]  BUS_ALL_ON      = 8'hFF;
  localparam logic [7:0]  BUS_OFF         = 8'h00;
  localparam logic [3:0]  NIBBLE_ZERO     = 4'h0;

  typedef enum logic [1:0] {
    SAHI_IDLE  = 2'b00,
    SAHI_TRIAL = 2'b01
  } sahi_sar_state_e;
endpackage

// [src/sahi_sar_if.sv]
// signals between the host control logic and the approximation sequencer
interface sahi_sar_if;
  import sahi_pkg::*;
  logic                start;
  logic                clear;
  logic                comp;
  logic                busy;
  logic                done;
  logic [RESULT_W-1:0] trial;

  modport ctrl (output start, output clear, output comp,
                input busy, input done, input trial);
  modport seq  (input start, input clear, input comp,
                output busy, output done, output trial);
endinterface

// [src/sahi_sar_seq.sv]
// successive approximation sequencer, one bit per clock, msb first
module sahi_sar_seq
  import sahi_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  sahi_sar_if.seq  sar
);
  sahi_sar_state_e      state_reg;
  sahi_sar_state_e      state_next;
  logic [RESULT_W-1:0]  code_reg;
  logic [RESULT_W-1:0]  code_next;
  logic [BIT_IDX_W-1:0] bit_reg;
  logic [BIT_IDX_W-1:0] bit_next;
  logic                 done_reg;
  logic                 done_next;
  logic [RESULT_W-1:0]  trial_bit;
  logic [RESULT_W-1:0]  kept;

  // current trial bit and the code after this bit is decided
  assign trial_bit = SAR_FIRST_TRIAL >> (SAR_TOP_BIT - bit_reg);
  assign kept      = sar.comp ? code_reg : (code_reg & ~trial_bit);
  assign sar.busy  = (state_reg == SAHI_TRIAL);
  assign sar.done  = done_reg;
  assign sar.trial = code_reg;

  // next state: clear beats start, start restarts at the msb
  always_comb begin
    state_next = state_reg;
    code_next  = code_reg;
    bit_next   = bit_reg;
    done_next  = 1'b0;
    if (sar.clear) begin
      state_next = SAHI_IDLE;
      code_next  = SAR_CODE_RESET;
    end else if (sar.start) begin
      state_next = SAHI_TRIAL; // RULE_20
      code_next  = SAR_FIRST_TRIAL;
      bit_next   = SAR_TOP_BIT;
    end else begin
      case (state_reg)
        SAHI_TRIAL: begin
          bit_next = bit_reg - 4'h1;
          if (bit_reg == 4'h0) begin
            code_next  = kept; // RULE_20
            state_next = SAHI_IDLE;
            done_next  = 1'b1;
          end else begin
            code_next = kept | (trial_bit >> 1);
          end
        end
        SAHI_IDLE: begin
          state_next = SAHI_IDLE;
        end
        default: begin
          state_next = SAHI_IDLE;
        end
      endcase
    end
  end

  // sequencer registers, advanced only by the converter clock
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= SAHI_IDLE;
      code_reg  <= SAR_CODE_RESET;
      bit_reg   <= 4'h0;
      done_reg  <= 1'b0;
    end else if (clk_en) begin // RULE_19
      state_reg <= state_next;
      code_reg  <= code_next;
      bit_reg   <= bit_next;
      done_reg  <= done_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !clk_en);

  a_msb_first_trial: assert property ( // RULE_20
    (sar.start && !sar.clear) |=> (sar.busy && sar.trial == SAR_FIRST_TRIAL))
    else $error("conversion did not start at the msb trial");
  a_done_after_lsb: assert property ( // RULE_20
    (sar.busy && bit_reg == 4'h0 && !sar.start && !sar.clear) |=> (sar.done && !sar.busy))
    else $error("completion not flagged after the last bit");
endmodule

// [src/sahi_adc_ctrl.sv]
// host bus control of a 12-bit successive approximation converter
// Function
// [RULE_01] completion output is released while converting, pulled low when data valid
// [RULE_02] modes 0 to 2: completion is gated by the read and write strobes
// [RULE_03] modes 3 and 4: completion shows converter status at all times
// [RULE_04] write with command select high loads the three low data lines
// [RULE_05] command picks output code and one of modes 0 to 3
// [RULE_06] low byte read drives eight result lsbs, line 0 the lsb
// [RULE_07] high byte read drives the four result msbs on lines 0 to 3
// [RULE_08] two's complement high byte repeats the sign on lines 4 to 7
// [RULE_09] mode 2 alternates low and high bytes itself, ignoring command select
// [RULE_10] the 12-bit result is returned in two byte reads
// [RULE_11] lines 0 to 2 are two-way, lines 3 to 7 output only
// [RULE_12] the host holds device select low during every access
// [RULE_13] mode 2: select high holds the sequencer cleared, its fall starts
// [RULE_14] mode 2: after the first result, reads start later conversions
// [RULE_15] modes 1 and 2 start on reads; reads always return result data
// [RULE_16] modes 0 and 3: a write restarts the sequencer
// [RULE_17] read and write strobes together force stand-alone conversion
// [RULE_18] stand-alone mode is reached by the pins only, never by command
// [RULE_19] conversion advances only on the supplied clock
// [RULE_20] one bit per clock, msb first, completion after twelve bits
// [RULE_21] data lines float unless a selected read is in progress
//
// The register offsets and strobed register access were left to the implementer.
module sahi_adc_ctrl
  import sahi_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                clk_en,
  input  wire logic                device_select_n,
  input  wire logic                read_strobe_n,
  input  wire logic                write_strobe_n,
  input  wire logic                command_or_data_select,
  input  wire logic [CMD_W-1:0]    data_in,
  input  wire logic                comp_in,
  output logic      [DATA_W-1:0]   data_out,
  output logic      [DATA_W-1:0]   data_oe,
  output logic                     conversion_done_n_out,
  output logic                     conversion_done_n_oe,
  output logic      [RESULT_W-1:0] dac_code
);
  sahi_sar_if sar ();

  // pin history, command and result registers
  logic [PIN_W-1:0]    s1_reg;
  logic [PIN_W-1:0]    s2_reg;
  logic [PIN_W-1:0]    s3_reg;
  logic [PIN_W-1:0]    filt_reg;
  logic [PIN_W-1:0]    filt_next;
  logic [PIN_W-1:0]    prev_reg;
  logic [CMD_W-1:0]    cmd_reg;
  logic                standalone_reg;
  logic                valid_reg;
  logic                valid_next;
  logic                first_done_reg;
  logic                first_done_next;
  logic                byte_hi_reg;
  logic                byte_hi_next;
  logic [RESULT_W-1:0] result_reg;
  logic [DATA_W-1:0]   data_out_reg;
  logic [DATA_W-1:0]   data_out_next;
  logic [DATA_W-1:0]   data_oe_reg;
  logic [DATA_W-1:0]   data_oe_next;
  logic                ack_oe_reg;
  logic                ack_oe_next;
  logic                ack_out_reg;

  // decoded pin levels, start sources and the data path
  logic                cs_act;
  logic                rd_act;
  logic                wr_act;
  logic                cd_hi;
  logic                both;
  logic                cs_fall;
  logic                rd_fall;
  logic                rd_rise;
  logic                wr_fall;
  logic [1:0]          mode;
  logic                twos;
  logic                dma;
  logic                dma_hold;
  logic                cmd_load;
  logic                wr_start;
  logic                rd_start;
  logic                cs_start;
  logic                sa_start;
  logic                reading;
  logic                read_hi;
  logic                conv_done;
  logic                gated;
  logic [RESULT_W-1:0] coded;
  logic [3:0]          fill;

  // true on the cycle an active-low strobe goes active
  function automatic logic sahi_fell(input logic prev_n, input logic cur_n);
    return prev_n & ~cur_n;
  endfunction

  // a pin change counts once the second and third stages agree
  assign filt_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & filt_reg);

  // filtered pin levels and their edges
  assign cs_act  = ~filt_reg[PIN_CS_BIT];
  assign rd_act  = ~filt_reg[PIN_RD_BIT];
  assign wr_act  = ~filt_reg[PIN_WR_BIT];
  assign cd_hi   = filt_reg[PIN_CD_BIT];
  assign cs_fall = sahi_fell(prev_reg[PIN_CS_BIT], filt_reg[PIN_CS_BIT]);
  assign rd_fall = sahi_fell(prev_reg[PIN_RD_BIT], filt_reg[PIN_RD_BIT]);
  assign wr_fall = sahi_fell(prev_reg[PIN_WR_BIT], filt_reg[PIN_WR_BIT]);
  assign rd_rise = sahi_fell(filt_reg[PIN_RD_BIT], prev_reg[PIN_RD_BIT]);
  assign both    = rd_act & wr_act; // RULE_17

  // command fields; stand-alone has no command code at all
  assign mode = cmd_reg[CMD_MODE_MSB:CMD_MODE_LSB]; // RULE_05
  assign twos = cmd_reg[CMD_CODE_BIT]; // RULE_05
  assign dma  = (mode == MODE_DMA) & ~standalone_reg;

  // conversion start and clear sources
  assign cmd_load = wr_fall & cs_act & cd_hi & ~both; // RULE_04 RULE_18
  assign wr_start = wr_fall & cs_act & ~cd_hi & ~both
                  & ((mode == MODE_WR_START) | (mode == MODE_WR_FREE)); // RULE_16
  assign rd_start = rd_fall & cs_act & ~both
                  & (((mode == MODE_RD_START) & cd_hi)
                  | (dma & first_done_reg & byte_hi_reg)); // RULE_14 RULE_15
  assign cs_start = cs_fall & dma & ~both; // RULE_13
  // held together, the strobes launch a new conversion at every valid result
  assign sa_start = both & (~standalone_reg | valid_reg); // RULE_17
  assign dma_hold = dma & ~cs_act & ~both; // RULE_13
  assign sar.start = sa_start | wr_start | rd_start | cs_start;
  assign sar.clear = dma_hold;
  assign sar.comp  = comp_in;

  // result flags: a completion wins over a coincident restart
  assign valid_next      = sar.done | (valid_reg & ~sar.start & ~sar.clear);
  assign first_done_next = (sar.done & dma) | (first_done_reg & ~dma_hold);
  // mode 2: the high-byte read of a result launches the next, keeping pairs coherent
  assign byte_hi_next    = dma_hold ? 1'b0
                         : ((rd_rise & cs_act & dma) ? ~byte_hi_reg : byte_hi_reg); // RULE_09

  // read data path: byte select, output code and sign fill
  assign reading = cs_act & rd_act & ~both; // RULE_21
  assign read_hi = dma ? byte_hi_reg : cd_hi; // RULE_09 RULE_10
  assign coded   = twos ? (result_reg ^ SIGN_FLIP) : result_reg;
  assign fill    = twos ? {4{coded[RESULT_W-1]}} : NIBBLE_ZERO; // RULE_08
  assign data_out_next = read_hi ? {fill, coded[RESULT_W-1:DATA_W]} // RULE_07
                                 : coded[DATA_W-1:0]; // RULE_06
  assign data_oe_next  = reading ? BUS_ALL_ON : BUS_OFF; // RULE_11 RULE_21

  // completion pin: gated in modes 0 to 2, free in modes 3 and 4
  // released while busy, so a strobe held during conversion sees wait states
  assign conv_done   = valid_reg & ~sar.busy; // RULE_01
  assign gated       = ~standalone_reg & (mode != MODE_WR_FREE); // RULE_02
  assign ack_oe_next = gated ? (conv_done & cs_act & (rd_act | wr_act)) // RULE_02
                             : conv_done; // RULE_03

  // pin synchroniser, three stages
  // one-cycle glitches never reach filt_reg: stages two and three must agree
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg   <= PIN_IDLE;
      s2_reg   <= PIN_IDLE;
      s3_reg   <= PIN_IDLE;
      filt_reg <= PIN_IDLE;
      prev_reg <= PIN_IDLE;
    end else if (clk_en) begin
      s1_reg   <= {device_select_n, read_strobe_n, write_strobe_n,
                   command_or_data_select, data_in};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
      prev_reg <= filt_reg;
    end
  end

  // command register and mode flags
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_reg        <= CMD_RESET;
      standalone_reg <= 1'b0;
      first_done_reg <= 1'b0;
      byte_hi_reg    <= 1'b0;
    end else if (clk_en) begin
      if (cmd_load) begin
        cmd_reg <= filt_reg[CMD_W-1:0]; // RULE_04
      end
      standalone_reg <= both; // RULE_17 RULE_18
      first_done_reg <= first_done_next;
      byte_hi_reg    <= byte_hi_next;
    end
  end

  // result capture and pin registers
  always_ff @(posedge clk) begin
    if (reset) begin
      valid_reg    <= 1'b0;
      result_reg   <= SAR_CODE_RESET;
      data_out_reg <= BUS_OFF;
      data_oe_reg  <= BUS_OFF;
      ack_oe_reg   <= 1'b0;
      ack_out_reg  <= 1'b0;
    end else if (clk_en) begin
      valid_reg <= valid_next;
      if (sar.done) begin
        result_reg <= sar.trial;
      end
      data_out_reg <= data_out_next; // RULE_15
      data_oe_reg  <= data_oe_next;
      ack_oe_reg   <= ack_oe_next; // RULE_01
      ack_out_reg  <= 1'b0;
    end
  end

  sahi_sar_seq u_seq (
    .clk    (clk),
    .reset  (reset),
    .clk_en (clk_en),
    .sar    (sar)
  );

  // the pins are driven from flip-flops only
  // open collector: the output only pulls low, the enable carries the status
  assign data_out              = data_out_reg;
  assign data_oe               = data_oe_reg;
  assign conversion_done_n_out = ack_out_reg;
  assign conversion_done_n_oe  = ack_oe_reg;
  assign dac_code              = sar.trial;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !clk_en);

  // data line drive, command, completion and start checks
  a_bus_float_idle: assert property (!reading |=> data_oe == BUS_OFF) // RULE_21
    else $error("data lines driven outside a selected read");
  a_bus_drive_read: assert property (reading |=> data_oe == BUS_ALL_ON) // RULE_11
    else $error("data lines not driven during a selected read");
  a_low_byte_data: assert property ( // RULE_06
    (reading && !read_hi && !twos) |=> data_out == $past(result_reg[7:0]))
    else $error("low byte read returned wrong data");
  a_sign_fill_hi: assert property ( // RULE_08
    (reading && read_hi && twos) |=> data_out[7:4] == {4{~$past(result_reg[11])}})
    else $error("sign not repeated on the upper lines");
  a_cmd_loaded: assert property ( // RULE_04
    cmd_load |=> cmd_reg == $past(filt_reg[CMD_W-1:0]))
    else $error("command register not loaded by the write");
  a_ack_ungated: assert property ( // RULE_03
    (!gated && conv_done) |=> conversion_done_n_oe)
    else $error("ungated completion not pulled low");
  a_ack_gated_idle: assert property ( // RULE_02
    (gated && !rd_act && !wr_act) |=> !conversion_done_n_oe)
    else $error("gated completion active without a strobe");
  a_ack_busy: assert property (sar.busy |=> !conversion_done_n_oe) // RULE_01
    else $error("completion low while converting");
  a_dma_hold_clear: assert property (dma_hold |=> !sar.busy) // RULE_13
    else $error("sequencer runs while select is high in mode 2");
  a_write_restart: assert property (wr_start |=> sar.busy) // RULE_16
    else $error("write did not start a conversion");
  a_standalone_go: assert property ((both && !standalone_reg) |=> sar.busy) // RULE_17
    else $error("both strobes did not force a conversion");

  // start sources launch the sequencer on the next cycle
  a_read_start: assert property (rd_start |=> sar.busy) // RULE_15
    else $error("read did not start a conversion");
  a_dma_first_go: assert property (cs_start |=> sar.busy) // RULE_13
    else $error("select fall did not start a conversion");
  a_dma_next_go: assert property ( // RULE_14
    (rd_fall && cs_act && dma && first_done_reg && byte_hi_reg && !both) |=> sar.busy)
    else $error("high byte read did not start a conversion");
  a_sa_restart: assert property ( // RULE_17
    (both && standalone_reg && valid_reg) |=> sar.busy)
    else $error("stand-alone did not restart");

  // read data and result capture
  a_hi_byte_data: assert property ( // RULE_07
    (reading && read_hi && !twos) |=> data_out == {NIBBLE_ZERO, $past(result_reg[11:8])})
    else $error("high byte read returned wrong data");
  a_twos_low_byte: assert property ( // RULE_05
    (reading && !read_hi && twos) |=> data_out == $past(result_reg[7:0]))
    else $error("two's complement low byte wrong");
  a_result_capture: assert property (sar.done |=> result_reg == $past(sar.trial)) // RULE_10
    else $error("result not captured");
  a_dma_byte_flip: assert property ( // RULE_09
    (rd_rise && cs_act && dma) |=> byte_hi_reg != $past(byte_hi_reg))
    else $error("mode 2 byte order did not advance");
  a_both_no_read: assert property (both |=> data_oe == BUS_OFF) // RULE_21
    else $error("data lines driven in stand-alone");

  // command and completion flag checks
  a_no_cmd_both: assert property (both |=> cmd_reg == $past(cmd_reg)) // RULE_18
    else $error("command changed by both strobes");
  a_desel_no_load: assert property ( // RULE_04
    (wr_fall && !cs_act) |=> cmd_reg == $past(cmd_reg))
    else $error("command loaded while deselected");
  a_valid_on_done: assert property (sar.done |=> valid_reg) // RULE_01
    else $error("result not flagged valid");
  a_ack_strobe: assert property ( // RULE_02
    (gated && conv_done && cs_act && rd_act) |=> conversion_done_n_oe)
    else $error("gated completion not pulled low in a read");

  // main scenarios reached
  c_dma_pair: cover property (dma && byte_hi_reg && rd_rise);
  c_standalone: cover property (standalone_reg && sar.done);
  c_twos_read: cover property (reading && read_hi && twos);
  c_dma_first: cover property (cs_start);
  c_gated_wait: cover property (gated && cs_act && rd_act && sar.busy);
endmodule

// [verification/sahi_host_model.sv]
// host bus and comparator model facing the converter control block
module sahi_host_model
  import sahi_pkg::*;
(
  input  wire logic                clk,
  output logic                     device_select_n,
  output logic                     read_strobe_n,
  output logic                     write_strobe_n,
  output logic                     command_or_data_select,
  output logic      [CMD_W-1:0]    data_in,
  output logic                     comp_in,
  input  wire logic [DATA_W-1:0]   data_out,
  input  wire logic [DATA_W-1:0]   data_oe,
  input  wire logic                conversion_done_n_out,
  input  wire logic                conversion_done_n_oe,
  input  wire logic [RESULT_W-1:0] dac_code,
  output logic                     done_level
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [RESULT_W-1:0] vin = 12'h000;
  logic [DATA_W-1:0]   last_bus = 8'h00;
  logic [DATA_W-1:0]   bus;
  logic [DATA_W-1:0]   oe_seen;

  // released lines show the inverse of the last driven level, never a stale value
  assign bus        = (data_oe & data_out) | (~data_oe & ~last_bus);
  // open collector with a pull-up on the completion line
  assign done_level = conversion_done_n_oe ? conversion_done_n_out : 1'b1;
  // ideal comparator: keep the trial bit while the trial code is not above the input
  assign comp_in    = (dac_code <= vin);

  always_ff @(posedge clk) last_bus <= (data_oe & data_out) | (~data_oe & last_bus);

  // strobes idle and select low from time zero
  initial begin
    device_select_n        = 1'b0;
    read_strobe_n          = 1'b1;
    write_strobe_n         = 1'b1;
    command_or_data_select = 1'b0;
    data_in                = 3'h0;
  end

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  // select is kept low across every access unless a test lifts it
  task automatic set_cs(input logic v);
    @(posedge clk);
    device_select_n <= v;
  endtask

  // one strobe access held for hold cycles, bus and completion taken at its last edge
  task automatic access(input logic rd_n, input logic wr_n, input logic cd,
                        input logic [CMD_W-1:0] d, input int hold,
                        output logic [DATA_W-1:0] seen, output logic ack);
    @(posedge clk);
    read_strobe_n          <= rd_n;
    write_strobe_n         <= wr_n;
    command_or_data_select <= cd;
    data_in                <= d;
    repeat (hold) @(posedge clk);
    seen = bus;
    oe_seen = data_oe;
    ack  = done_level;
    read_strobe_n  <= 1'b1;
    write_strobe_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

// [verification/sar_adc_host_interface_tb_top.sv]
// self-checking bench for the converter host interface
module sar_adc_host_interface_tb_top
  import sahi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                clk;
  logic                reset;
  logic                clk_en;
  logic                device_select_n;
  logic                read_strobe_n;
  logic                write_strobe_n;
  logic                command_or_data_select;
  logic [CMD_W-1:0]    data_in;
  logic                comp_in;
  logic [DATA_W-1:0]   data_out;
  logic [DATA_W-1:0]   data_oe;
  logic                conversion_done_n_out;
  logic                conversion_done_n_oe;
  logic [RESULT_W-1:0] dac_code;
  logic                done_level;
  logic [DATA_W-1:0]   seen;
  logic                ack;
  int                  bad_count = 0;
  int                  samples_checked = 0;
  int                  cycle_count = 0;

  sahi_adc_ctrl dut (
    .clk(clk), .reset(reset), .clk_en(clk_en), .device_select_n(device_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .command_or_data_select(command_or_data_select), .data_in(data_in),
    .comp_in(comp_in), .data_out(data_out), .data_oe(data_oe),
    .conversion_done_n_out(conversion_done_n_out),
    .conversion_done_n_oe(conversion_done_n_oe), .dac_code(dac_code)
  );

  sahi_host_model host (
    .clk(clk), .device_select_n(device_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .command_or_data_select(command_or_data_select),
    .data_in(data_in), .comp_in(comp_in), .data_out(data_out), .data_oe(data_oe),
    .conversion_done_n_out(conversion_done_n_out),
    .conversion_done_n_oe(conversion_done_n_oe), .dac_code(dac_code),
    .done_level(done_level)
  );

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a command write: mode in the low two lines, code select on line 2
  task automatic cmd(input logic twos, input logic [1:0] mode);
    host.access(1'b1, 1'b0, 1'b1, {twos, mode}, 8, seen, ack);
  endtask

  task automatic rd(input logic cd);
    host.access(1'b0, 1'b1, cd, 3'h0, 8, seen, ack);
  endtask

  task automatic test_reset();
    check(data_oe, BUS_OFF);
    check(dac_code, SAR_CODE_RESET);
    check(done_level, 1'b1);
    $display("reset test done");
  endtask

  // write-started conversion, gated completion, both bytes in offset binary
  task automatic test_mode0();
    cmd(1'b0, MODE_WR_START);
    host.vin = 12'hC3E;
    host.access(1'b1, 1'b0, 1'b0, 3'h0, 8, seen, ack);
    host.wait_cycles(20);
    check(done_level, 1'b1);
    check(data_oe, BUS_OFF);
    rd(1'b0);
    check(seen, 8'h3E);
    check(ack, 1'b0);
    check(data_oe, BUS_OFF);
    check(host.oe_seen, BUS_ALL_ON);
    rd(1'b1);
    check(seen, 8'h0C);
    $display("mode 0 test done");
  endtask

  // high-byte read starts a conversion and shows a wait state
  task automatic test_mode1();
    cmd(1'b0, MODE_RD_START);
    host.vin = 12'h5A7;
    rd(1'b1);
    check(seen, 8'h0C);
    check(ack, 1'b1);
    host.wait_cycles(20);
    rd(1'b0);
    check(seen, 8'hA7);
    rd(1'b1);
    check(seen, 8'h05);
    $display("mode 1 test done");
  endtask

  // select-started first conversion, then read-started ones, bytes sequenced inside
  task automatic test_mode2();
    cmd(1'b0, MODE_DMA);
    host.set_cs(1'b1);
    host.wait_cycles(10);
    check(dac_code, SAR_CODE_RESET);
    host.vin = 12'h9B4;
    host.set_cs(1'b0);
    host.wait_cycles(25);
    rd(1'b1);
    check(seen, 8'hB4);
    host.vin = 12'h26D;
    rd(1'b1);
    check(seen, 8'h09);
    host.wait_cycles(25);
    rd(1'b0);
    check(seen, 8'h6D);
    rd(1'b0);
    check(seen, 8'h02);
    $display("mode 2 test done");
  endtask

  // ungated completion, refused deselected write, sign fill in two's complement
  task automatic test_mode3();
    cmd(1'b1, MODE_WR_FREE);
    host.vin = 12'h3A5;
    host.access(1'b1, 1'b0, 1'b0, 3'h0, 8, seen, ack);
    host.wait_cycles(20);
    check(done_level, 1'b0);
    host.set_cs(1'b1);
    cmd(1'b0, MODE_WR_START);
    rd(1'b0);
    check(host.oe_seen, BUS_OFF);
    host.set_cs(1'b0);
    check(done_level, 1'b0);
    rd(1'b1);
    check(seen, 8'hFB);
    rd(1'b0);
    check(seen, 8'hA5);
    $display("mode 3 test done");
  endtask

  // both strobes together convert without select and never load the command
  task automatic test_standalone();
    cmd(1'b0, MODE_WR_START);
    host.vin = 12'h7F0;
    host.set_cs(1'b1);
    host.access(1'b0, 1'b0, 1'b1, 3'h3, 40, seen, ack);
    host.set_cs(1'b0);
    host.wait_cycles(20);
    check(done_level, 1'b1);
    rd(1'b0);
    check(seen, 8'hF0);
    $display("stand-alone test done");
  endtask

  // clock enable low freezes sequencer and pins until it rises again
  task automatic test_freeze();
    logic [RESULT_W-1:0] held;
    host.vin = 12'h4C1;
    host.access(1'b1, 1'b0, 1'b0, 3'h0, 8, seen, ack);
    clk_en <= 1'b0;
    host.wait_cycles(2);
    held = dac_code;
    cmd(1'b1, MODE_WR_FREE);
    check(dac_code, held);
    check(done_level, 1'b1);
    clk_en <= 1'b1;
    host.wait_cycles(20);
    rd(1'b1);
    check(seen, 8'h04);
    check(ack, 1'b0);
    $display("freeze test done");
  endtask

  // a reset in mid-run clears the result and its valid flag
  task automatic test_reset_mid();
    reset <= 1'b1;
    host.wait_cycles(2);
    reset <= 1'b0;
    host.wait_cycles(1);
    check(dac_code, SAR_CODE_RESET);
    check(data_oe, BUS_OFF);
    check(done_level, 1'b1);
    rd(1'b0);
    check(seen, 8'h00);
    check(ack, 1'b1);
    $display("mid-run reset test done");
  endtask

  // hang guard
  always @(posedge clk) begin
    cycle_count++;
    if (cycle_count == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // main sequence
  initial begin
    reset  = 1'b1;
    clk_en = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    test_reset();
    test_mode0();
    test_mode1();
    test_mode2();
    test_mode3();
    test_standalone();
    test_freeze();
    test_reset_mid();
    summarize();
  end
endmodule
